// File: hdl/tmr_pkg.sv
// Purpose: shared constants and types for the timer channel setup block
// Assumes: 16-bit register bus, registers on word-aligned byte addresses
// Notes:   offsets, field positions and reset values live here; the checker repeats bit positions 5 and 11 as literals
package tmr_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } bus_req_s;

    // register byte addresses
    localparam logic [ADDR_W-1:0] OFS_PORT_DIR  = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CLK_GATE  = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_PRESCALE  = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_CH0_MODE  = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_CH0_CTRL  = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT  = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK  = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_CH0_COUNT = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_CH0_DATA  = 8'h20;

    // field positions
    localparam int PIN5_BIT   = 5;
    localparam int GATE_BIT   = 0;
    localparam int PRS0_LSB   = 0;
    localparam int PRS1_LSB   = 4;
    localparam int PRS2_LSB   = 8;
    localparam int PRS3_LSB   = 12;
    localparam int CKS_LSB    = 14;
    localparam int CCS_BIT    = 12;
    localparam int MASTER_BIT = 11;
    localparam int STS_LSB    = 8;
    localparam int CIS_LSB    = 6;
    localparam int MD_LSB     = 0;
    localparam int CTRL_START = 0;
    localparam int CTRL_STOP  = 1;
    localparam int EV_TIMER   = 0;
    localparam int EV_START   = 1;
    localparam int EV_W       = 2;

    // reset values and writable masks
    localparam logic [7:0]  PORT_DIR_RST  = 8'hFF;
    localparam logic [7:0]  PORT_DIR_FIX  = 8'h80;
    localparam logic [7:0]  CLK_GATE_RST  = 8'h00;
    localparam logic [7:0]  CLK_GATE_WMSK = 8'hFD;
    localparam logic [15:0] PRESCALE_RST  = 16'h0000;
    localparam logic [15:0] PRESCALE_WMSK = 16'h33FF;
    localparam logic [15:0] MODE_RST      = 16'h0000;
    localparam logic [15:0] MODE_WMSK     = 16'hDFCF;
    localparam logic [15:0] DATA_RST      = 16'hFFFF;
    localparam logic [EV_W-1:0] MASK_RST  = 2'h0;

    // channel clock select codes
    localparam logic [1:0] CKS_CK0 = 2'h0;
    localparam logic [1:0] CKS_CK2 = 2'h1;
    localparam logic [1:0] CKS_CK1 = 2'h2;
    localparam logic [1:0] CKS_CK3 = 2'h3;

    // start trigger and edge codes
    localparam logic [2:0] STS_SOFT  = 3'h0;
    localparam logic [2:0] STS_EDGE  = 3'h1;
    localparam logic [2:0] STS_BOTH  = 3'h2;
    localparam logic [1:0] CIS_FALL  = 2'h0;
    localparam logic [1:0] CIS_RISE  = 2'h1;

    typedef enum logic {ST_IDLE, ST_RUN} chan_state_e;

endpackage : tmr_pkg

// File: hdl/tmr_prescaler.sv
// Purpose: power-of-two operation clock enables for the timer unit
// Assumes: i_run low stops the divider chain and all ticks
// Notes:   ticks are one-cycle enables, not derived clocks
`timescale 1ns/1ps
`default_nettype none
module tmr_prescaler #(
    parameter int DIV_W = 15
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    input  wire logic        i_ce,
    input  wire logic        i_run,
    input  wire logic [15:0] i_sel,
    output var  logic [3:0]  o_tick
);
    import tmr_pkg::*;

    logic [DIV_W-1:0] cnt_reg;
    logic [3:0]       tick_next;

    // exponent n: tick when the low n divider bits are all ones
    function automatic logic tick_of(input logic [DIV_W-1:0] c, input logic [3:0] n);
        logic [DIV_W-1:0] m;
        m = ~({DIV_W{1'b1}} << n);
        return (c & m) == m;
    endfunction : tick_of

    assign tick_next[0] = i_run & tick_of(cnt_reg, i_sel[PRS0_LSB+:4]);
    assign tick_next[1] = i_run & tick_of(cnt_reg, i_sel[PRS1_LSB+:4]);
    assign tick_next[2] = i_run & tick_of(cnt_reg, {2'h0, i_sel[PRS2_LSB+:2]});
    assign tick_next[3] = i_run & tick_of(cnt_reg, {2'h0, i_sel[PRS3_LSB+:2]});

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_reg <= '0;
            o_tick  <= 4'h0;
        end else if (i_ce) begin
            if (i_run) begin
                cnt_reg <= cnt_reg + 1'b1;
            end
            o_tick <= tick_next;
        end
    end

endmodule : tmr_prescaler
`default_nettype wire

// File: hdl/timer_channel_clock_setup.sv
// Purpose: timer unit clock gate, prescaler, channel 0 clock/mode setup
// Assumes: one clock; external timer input is asynchronous
// Notes:   only interval counting is modelled; other modes count the same
`timescale 1ns/1ps
`default_nettype none
// Function
// - pin5 direction 0 drives, 1 releases
// - gate bit 0 stops unit clock
// - clock zero is fCLK over 2^code
// - clock select 00/01/10/11 picks 0/2/1/3
// - count clock: operation clock or input edge
// - master bit selects master role
// - trigger code 000 allows software start only
// - interval counts down; option bit: start interrupt
module timer_channel_clock_setup #(
    parameter int CNT_W = 16
) (
    input  wire logic                      I_CLK,
    input  wire logic                      I_RST_B,
    input  wire logic                      I_CE,
    input  wire tmr_pkg::bus_req_s         I_BUS,
    output var  logic [tmr_pkg::DATA_W-1:0] O_RDATA,
    input  wire logic                      I_EXT_IN,
    output var  logic                      O_PIN5_OUT,
    output var  logic                      O_PIN5_OE,
    output var  logic                      O_MASTER,
    output var  logic                      O_CH_IRQ,
    output var  logic                      O_IRQ
);
    import tmr_pkg::*;

    // software-visible registers
    logic [7:0]       port_dir_reg;
    logic [7:0]       clk_gate_reg;
    logic [15:0]      prescale_reg;
    logic [15:0]      mode_reg;
    logic [15:0]      data_reg;
    logic [EV_W-1:0]  stat_reg;
    logic [EV_W-1:0]  stat_next;
    logic [EV_W-1:0]  mask_reg;

    // channel state
    chan_state_e      state_reg;
    logic [CNT_W-1:0] count_reg;
    logic             tout_reg;
    logic             ev_timer_reg;
    logic             ev_start_reg;

    // external input synchroniser and filter
    logic             ext_s1_reg;
    logic             ext_s2_reg;
    logic             ext_s3_reg;
    logic             ext_lvl_reg;

    // decoded bus access
    wire sel_port_dir  = I_BUS.addr == OFS_PORT_DIR;
    wire sel_clk_gate  = I_BUS.addr == OFS_CLK_GATE;
    wire sel_prescale  = I_BUS.addr == OFS_PRESCALE;
    wire sel_mode      = I_BUS.addr == OFS_CH0_MODE;
    wire sel_ctrl      = I_BUS.addr == OFS_CH0_CTRL;
    wire sel_stat      = I_BUS.addr == OFS_IRQ_STAT;
    wire sel_mask      = I_BUS.addr == OFS_IRQ_MASK;
    wire sel_count     = I_BUS.addr == OFS_CH0_COUNT;
    wire sel_data      = I_BUS.addr == OFS_CH0_DATA;

    wire wr_port_dir   = I_BUS.wr & sel_port_dir;
    wire wr_clk_gate   = I_BUS.wr & sel_clk_gate;
    wire wr_prescale   = I_BUS.wr & sel_prescale;
    wire wr_mode       = I_BUS.wr & sel_mode;
    wire wr_ctrl       = I_BUS.wr & sel_ctrl;
    wire wr_stat       = I_BUS.wr & sel_stat;
    wire wr_mask       = I_BUS.wr & sel_mask;
    wire wr_data       = I_BUS.wr & sel_data;

    // mode register fields
    wire [1:0] cks     = mode_reg[CKS_LSB+:2];
    wire       ccs     = mode_reg[CCS_BIT];
    wire [2:0] sts     = mode_reg[STS_LSB+:3];
    wire [1:0] cis     = mode_reg[CIS_LSB+:2];
    wire       md_opt  = mode_reg[MD_LSB];

    wire unit_run      = clk_gate_reg[GATE_BIT];

    wire [3:0] op_tick;

    tmr_prescaler #(
        .DIV_W (15)
    ) u_prescaler (
        .i_clk   (I_CLK),
        .i_rst_b (I_RST_B),
        .i_ce    (I_CE),
        .i_run   (unit_run),
        .i_sel   (prescale_reg),
        .o_tick  (op_tick)
    );

    wire master_tick = (cks == CKS_CK0) ? op_tick[0] :
                       (cks == CKS_CK2) ? op_tick[2] :
                       (cks == CKS_CK1) ? op_tick[1] : op_tick[3];

    // edges seen on the filtered level only, never on the raw sync stage
    wire ext_change    = (ext_s2_reg == ext_s3_reg) && (ext_s3_reg != ext_lvl_reg);
    wire ext_rise      = ext_change & ext_s3_reg;
    wire ext_fall      = ext_change & ~ext_s3_reg;
    wire ext_valid     = (cis == CIS_FALL) ? ext_fall :
                         (cis == CIS_RISE) ? ext_rise : ext_change;

    wire count_tick    = ccs ? ext_valid : master_tick;

    // software-only start when code is 000
    wire edge_start    = ((sts == STS_EDGE) & ext_valid) | ((sts == STS_BOTH) & ext_change);
    wire soft_start    = wr_ctrl & I_BUS.wdata[CTRL_START];
    wire start_req     = soft_start | ((sts != STS_SOFT) & edge_start);
    wire stop_req      = wr_ctrl & I_BUS.wdata[CTRL_STOP];

    wire running       = state_reg == ST_RUN;
    wire count_zero    = count_reg == '0;
    wire ch_active     = I_CE & unit_run;

    wire start_event   = start_req & md_opt;
    wire wrap_event    = running & count_tick & count_zero & ~start_req & ~stop_req;
    wire timer_event   = start_event | wrap_event;

    wire [EV_W-1:0] ev_vec;
    assign ev_vec[EV_TIMER] = ev_timer_reg;
    assign ev_vec[EV_START] = ev_start_reg;

    // set wins over write-one-to-clear
    assign stat_next = (stat_reg & ~(wr_stat ? I_BUS.wdata[EV_W-1:0] : {EV_W{1'b0}})) | ev_vec;

    // read mux
    wire [15:0] rd_mux =
        sel_port_dir  ? {8'h00, port_dir_reg | PORT_DIR_FIX} :
        sel_clk_gate  ? {8'h00, clk_gate_reg} :
        sel_prescale  ? prescale_reg :
        sel_mode      ? mode_reg :
        sel_ctrl      ? {15'h0000, running} :
        sel_stat      ? {{(16-EV_W){1'b0}}, stat_reg} :
        sel_mask      ? {{(16-EV_W){1'b0}}, mask_reg} :
        sel_count     ? count_reg[15:0] :
        sel_data      ? data_reg : 16'h0000;

    // configuration registers
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            port_dir_reg <= PORT_DIR_RST;
            clk_gate_reg <= CLK_GATE_RST;
            prescale_reg <= PRESCALE_RST;
            mode_reg     <= MODE_RST;
            data_reg     <= DATA_RST;
            mask_reg     <= MASK_RST;
        end else if (I_CE) begin
            if (wr_port_dir) begin
                port_dir_reg <= I_BUS.wdata[7:0] | PORT_DIR_FIX;
            end
            if (wr_clk_gate) begin
                clk_gate_reg <= I_BUS.wdata[7:0] & CLK_GATE_WMSK;
            end
            if (wr_prescale) begin
                prescale_reg <= I_BUS.wdata & PRESCALE_WMSK;
            end
            if (wr_mode) begin
                mode_reg <= I_BUS.wdata & MODE_WMSK;
            end
            if (wr_data) begin
                data_reg <= I_BUS.wdata;
            end
            if (wr_mask) begin
                mask_reg <= I_BUS.wdata[EV_W-1:0];
            end
        end
    end

    // status, read data and interrupt
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            stat_reg <= '0;
            O_RDATA  <= 16'h0000;
            O_IRQ    <= 1'b0;
        end else if (I_CE) begin
            stat_reg <= stat_next;
            O_RDATA  <= I_BUS.rd ? rd_mux : 16'h0000;
            O_IRQ    <= |(stat_next & mask_reg);
        end
    end

    // three-stage input capture
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            ext_s1_reg  <= 1'b0;
            ext_s2_reg  <= 1'b0;
            ext_s3_reg  <= 1'b0;
            ext_lvl_reg <= 1'b0;
        end else if (I_CE) begin
            ext_s1_reg <= I_EXT_IN;
            ext_s2_reg <= ext_s1_reg;
            ext_s3_reg <= ext_s2_reg;
            if (ext_s2_reg == ext_s3_reg) begin
                ext_lvl_reg <= ext_s3_reg;
            end
        end
    end

    // channel counter; held while the unit clock is gated, event pulses forced low
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            state_reg    <= ST_IDLE;
            count_reg    <= '0;
            tout_reg     <= 1'b0;
            ev_timer_reg <= 1'b0;
            ev_start_reg <= 1'b0;
        end else if (I_CE) begin
            ev_timer_reg <= ch_active & timer_event;
            ev_start_reg <= ch_active & start_req;
            if (ch_active) begin
                if (timer_event) begin
                    tout_reg <= ~tout_reg;
                end
                case (state_reg)
                    ST_IDLE: begin
                        if (start_req) begin
                            state_reg <= ST_RUN;
                            count_reg <= data_reg[CNT_W-1:0];
                        end
                    end
                    ST_RUN: begin
                        if (stop_req) begin
                            state_reg <= ST_IDLE;
                        end else if (start_req) begin
                            count_reg <= data_reg[CNT_W-1:0];
                        end else if (count_tick) begin
                            count_reg <= count_zero ? data_reg[CNT_W-1:0]
                                                    : count_reg - 1'b1;
                        end
                    end
                    default: begin
                        state_reg <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // pin and role outputs
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_PIN5_OUT <= 1'b0;
            O_PIN5_OE  <= 1'b0;
            O_MASTER   <= 1'b0;
            O_CH_IRQ   <= 1'b0;
        end else if (I_CE) begin
            O_PIN5_OUT <= tout_reg;
            O_PIN5_OE  <= ~port_dir_reg[PIN5_BIT];
            O_MASTER   <= mode_reg[MASTER_BIT];
            O_CH_IRQ   <= ev_timer_reg;
        end
    end

endmodule : timer_channel_clock_setup
`default_nettype wire

// File: tb/timer_channel_clock_setup_checker.sv
// Purpose: port-level checks for the timer channel setup block
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   gate state is mirrored from bus writes, not read from the design
`timescale 1ns/1ps
`default_nettype none
module timer_channel_clock_setup_checker (
    input wire logic                      I_CLK,
    input wire logic                      I_RST_B,
    input wire logic                      I_CE,
    input wire tmr_pkg::bus_req_s         I_BUS,
    input wire logic [tmr_pkg::DATA_W-1:0] O_RDATA,
    input wire logic                      O_PIN5_OUT,
    input wire logic                      O_PIN5_OE,
    input wire logic                      O_MASTER,
    input wire logic                      O_CH_IRQ,
    input wire logic                      O_IRQ
);
    import tmr_pkg::*;
    logic       gate_reg;
    logic [3:0] off_cnt_reg;
    wire logic  wr_ok   = I_CE && I_BUS.wr;
    wire logic  rd_ok   = I_CE && I_BUS.rd;
    wire logic  wr_dir  = wr_ok && (I_BUS.addr == OFS_PORT_DIR);
    wire logic  wr_mode = wr_ok && (I_BUS.addr == OFS_CH0_MODE);
    wire logic  wr_gate = wr_ok && (I_BUS.addr == OFS_CLK_GATE);
    wire logic  wr_irq  = wr_ok && ((I_BUS.addr == OFS_IRQ_STAT) || (I_BUS.addr == OFS_IRQ_MASK));
    wire logic  rd_dir  = rd_ok && (I_BUS.addr == OFS_PORT_DIR);
    wire logic  rd_mode = rd_ok && (I_BUS.addr == OFS_CH0_MODE);
    wire logic  rd_gate = rd_ok && (I_BUS.addr == OFS_CLK_GATE);

    // saturating count of cycles spent with the unit clock stopped
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            gate_reg    <= 1'b0;
            off_cnt_reg <= 4'h0;
        end else begin
            if (wr_gate) begin
                gate_reg <= I_BUS.wdata[GATE_BIT];
            end
            if (gate_reg) begin
                off_cnt_reg <= 4'h0;
            end else if (off_cnt_reg != 4'hF) begin
                off_cnt_reg <= off_cnt_reg + 4'h1;
            end
        end
    end

    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RST_B);

    property p_rdata_idle;
        $past(I_CE) && !$past(I_BUS.rd) |-> O_RDATA == 16'h0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
    property p_dir_change;
        $changed(O_PIN5_OE) |-> ($past(wr_dir) && O_PIN5_OE != $past(I_BUS.wdata[5]))
            || ($past(wr_dir, 2) && O_PIN5_OE != $past(I_BUS.wdata[5], 2));
    endproperty
    a_dir_change: assert property (p_dir_change) else $error("pin enable moved wrongly");
    property p_dir_read;
        $past(rd_dir) |-> O_RDATA[15:8] == 8'h00 && O_RDATA[7] && O_RDATA[5] != O_PIN5_OE;
    endproperty
    a_dir_read: assert property (p_dir_read) else $error("direction readback wrong");
    property p_master_change;
        $changed(O_MASTER) |-> ($past(wr_mode) && O_MASTER == $past(I_BUS.wdata[11]))
            || ($past(wr_mode, 2) && O_MASTER == $past(I_BUS.wdata[11], 2));
    endproperty
    a_master_change: assert property (p_master_change) else $error("master moved wrongly");
    property p_mode_read;
        $past(rd_mode) |-> O_RDATA[11] == O_MASTER && !O_RDATA[13] && O_RDATA[5:4] == 2'h0;
    endproperty
    a_mode_read: assert property (p_mode_read) else $error("mode readback wrong");
    property p_gate_read;
        $past(rd_gate) |-> O_RDATA[15:1] == 15'h0000 && O_RDATA[0] == gate_reg;
    endproperty
    a_gate_read: assert property (p_gate_read) else $error("gate readback wrong");
    property p_gate_freeze;
        off_cnt_reg == 4'hF |-> !O_CH_IRQ && $stable(O_PIN5_OUT);
    endproperty
    a_gate_freeze: assert property (p_gate_freeze) else $error("activity with gate off");
    property p_irq_fall;
        $fell(O_IRQ) |-> $past(wr_irq) || $past(wr_irq, 2) || $past(wr_irq, 3);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped by itself");
endmodule : timer_channel_clock_setup_checker

bind timer_channel_clock_setup timer_channel_clock_setup_checker u_chk (
    .I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_CE(I_CE), .I_BUS(I_BUS), .O_RDATA(O_RDATA),
    .O_PIN5_OUT(O_PIN5_OUT), .O_PIN5_OE(O_PIN5_OE), .O_MASTER(O_MASTER),
    .O_CH_IRQ(O_CH_IRQ), .O_IRQ(O_IRQ));
`default_nettype wire

// File: tb/timer_channel_clock_setup_tb.sv
// Purpose: register-level bench for the timer channel setup block
// Assumes: one idle cycle between bus strobes
// Notes:   clock enable dropped once; periods measured between interrupts
`timescale 1ns/1ps
`default_nettype none
module timer_channel_clock_setup_tb;
    import tmr_pkg::*;
    logic        clk;
    logic        rst_b;
    logic        ce;
    logic        ext_in;
    bus_req_s    bus;
    logic [15:0] rdata;
    logic        pin5_out;
    logic        pin5_oe;
    logic        master;
    logic        ch_irq;
    logic        irq;
    logic [15:0] v;
    logic [15:0] g;
    logic        o;
    int          failures;
    int          cmp_count;
    int          cyc;
    int          pulses;
    int          p0;
    logic [15:0] ps_tbl [6] = '{16'h3210, 16'h3213, 16'h3215, 16'h3210, 16'h3210, 16'h3210};
    logic [1:0]  ck_tbl [6] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h3};
    int          sh_tbl [6] = '{0, 3, 5, 2, 1, 3};

    timer_channel_clock_setup u_dut (
        .I_CLK(clk), .I_RST_B(rst_b), .I_CE(ce), .I_BUS(bus), .O_RDATA(rdata),
        .I_EXT_IN(ext_in), .O_PIN5_OUT(pin5_out), .O_PIN5_OE(pin5_oe),
        .O_MASTER(master), .O_CH_IRQ(ch_irq), .O_IRQ(irq));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (ch_irq === 1'b1) pulses <= pulses + 1;
        if (cyc == 20000) begin
            failures = failures + 1;
            print_verdict();
        end
    end

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : print_verdict

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk16

    task automatic chk1(input logic got, input logic exp);
        chk16({15'h0000, got}, {15'h0000, exp});
    endtask : chk1

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk) bus <= '{a, d, 1'b0, 1'b0};
    endtask : wr

    // data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk) bus <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge clk) bus <= '{a, 16'h0000, 1'b0, 1'b0};
        #1 d = rdata;
    endtask : rd

    task automatic rchk(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] d;
        rd(a, d);
        chk16(d, e);
    endtask : rchk

    task automatic settle;
        repeat (8) @(posedge clk);
        #1;
    endtask : settle

    task automatic next_pulse(output int c);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ch_irq !== 1'b1 && n < 4000);
        c = cyc;
    endtask : next_pulse

    // first pulse skipped so restart transients do not count
    task automatic gap(output logic [15:0] p);
        int a;
        int b;
        next_pulse(a);
        next_pulse(a);
        next_pulse(b);
        p = 16'(b - a);
    endtask : gap

    task automatic edges(input int n);
        repeat (n) begin
            repeat (8) @(posedge clk);
            ext_in <= 1'b1;
            repeat (8) @(posedge clk);
            ext_in <= 1'b0;
        end
    endtask : edges

    initial begin
        rst_b = 1'b0;
        ext_in = 1'b0;
        bus = '0;
        ce = 1'b1;
        failures = 0;
        cmp_count = 0;
        cyc = 0;
        pulses = 0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rchk(OFS_PORT_DIR, 16'h00FF);
        chk1(pin5_oe, 1'b0);
        rchk(OFS_CLK_GATE, 16'h0000);
        rchk(OFS_PRESCALE, 16'h0000);
        rchk(OFS_CH0_MODE, 16'h0000);
        rchk(OFS_IRQ_MASK, 16'h0000);
        wr(8'h40, 16'hFFFF);
        rchk(8'h40, 16'h0000);
        wr(OFS_PORT_DIR, 16'h0000);
        rchk(OFS_PORT_DIR, 16'h0080);
        chk1(pin5_oe, 1'b1);
        wr(OFS_PORT_DIR, 16'h0020);
        rchk(OFS_PORT_DIR, 16'h00A0);
        chk1(pin5_oe, 1'b0);
        // a write while the clock enable is low must be lost
        @(posedge clk) ce <= 1'b0;
        wr(OFS_PORT_DIR, 16'h0000);
        ce <= 1'b1;
        rchk(OFS_PORT_DIR, 16'h00A0);
        chk1(pin5_oe, 1'b0);
        // start with the unit clock stopped must be ignored
        wr(OFS_CH0_MODE, 16'h0001);
        wr(OFS_CH0_DATA, 16'h0003);
        wr(OFS_CH0_CTRL, 16'h0001);
        repeat (20) @(posedge clk);
        rchk(OFS_CH0_CTRL, 16'h0000);
        chk16(16'(pulses), 16'h0000);
        wr(OFS_CLK_GATE, 16'h0001);
        rchk(OFS_CLK_GATE, 16'h0001);
        for (int i = 0; i < 6; i++) begin
            wr(OFS_PRESCALE, ps_tbl[i]);
            wr(OFS_CH0_MODE, {ck_tbl[i], 14'h0000});
            wr(OFS_CH0_CTRL, 16'h0001);
            gap(g);
            chk16(g, 16'h0004 << sh_tbl[i]);
        end
        rchk(OFS_CH0_CTRL, 16'h0001);
        wr(OFS_PRESCALE, 16'h0000);
        wr(OFS_CH0_MODE, 16'h1000);
        wr(OFS_CH0_DATA, 16'h0001);
        wr(OFS_CH0_CTRL, 16'h0001);
        p0 = pulses;
        edges(6);
        settle();
        chk16(16'(pulses - p0), 16'h0003);
        wr(OFS_CH0_CTRL, 16'h0002);
        edges(2);
        rchk(OFS_CH0_CTRL, 16'h0000);
        // edge trigger code: a falling input edge starts the channel
        wr(OFS_CH0_MODE, 16'h0100);
        edges(1);
        settle();
        rchk(OFS_CH0_CTRL, 16'h0001);
        wr(OFS_CH0_MODE, 16'hFFFF);
        rchk(OFS_CH0_MODE, 16'hDFCF);
        chk1(master, 1'b1);
        wr(OFS_CH0_MODE, 16'h0000);
        rchk(OFS_CH0_MODE, 16'h0000);
        chk1(master, 1'b0);
        wr(OFS_CH0_DATA, 16'h0100);
        for (int md = 0; md < 2; md++) begin
            wr(OFS_CH0_MODE, 16'(md));
            wr(OFS_CH0_CTRL, 16'h0002);
            settle();
            p0 = pulses;
            o = pin5_out;
            wr(OFS_CH0_CTRL, 16'h0001);
            settle();
            chk16(16'(pulses - p0), 16'(md));
            chk1(pin5_out, o ^ md[0]);
        end
        rd(OFS_CH0_COUNT, v);
        rd(OFS_CH0_COUNT, g);
        chk1(g < v, 1'b1);
        chk1(irq, 1'b0);
        wr(OFS_IRQ_MASK, 16'h0003);
        settle();
        chk1(irq, 1'b1);
        wr(OFS_IRQ_MASK, 16'h0000);
        settle();
        chk1(irq, 1'b0);
        wr(OFS_IRQ_MASK, 16'h0003);
        wr(OFS_CH0_CTRL, 16'h0002);
        wr(OFS_IRQ_STAT, 16'h0003);
        settle();
        chk1(irq, 1'b0);
        rchk(OFS_IRQ_STAT, 16'h0000);
        print_verdict();
    end
endmodule : timer_channel_clock_setup_tb
`default_nettype wire
